// [ebcs_pkg.sv]
// Shared constants, region map and state encoding for the external bus port
package ebcs_pkg;
    localparam int ADDR_W = 24;                  // Address bus width
    localparam int DATA_W = 8;                   // Data bus width
    localparam int NUM_CS = 4;                   // Number of region selects

    localparam logic [ADDR_W-1:0] ADDR_RST  = 24'h000000;  // Address after reset
    localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;       // Data after reset
    localparam logic [NUM_CS-1:0] CS_IDLE   = 4'hf;        // All selects inactive
    localparam logic              STB_OFF   = 1'b1;        // Strobe inactive level
    localparam logic              STB_ON    = 1'b0;        // Strobe active level
    localparam logic              OE_OFF    = 1'b1;        // Pin released
    localparam logic              OE_ON     = 1'b0;        // Pin driven

    // Default region map; base is compared under mask
    localparam logic [ADDR_W-1:0] REGION_BASE [NUM_CS] =
        '{24'h000000, 24'h040000, 24'h080000, 24'h000100};
    localparam logic [ADDR_W-1:0] REGION_MASK [NUM_CS] =
        '{24'hfc0000, 24'hfc0000, 24'hfc0000, 24'hffff00};
    localparam logic              REGION_IO   [NUM_CS] =
        '{1'b0, 1'b0, 1'b0, 1'b1};

    // Bus cycle sequencer states
    typedef enum logic [1:0] {
        EBCS_IDLE  = 2'b00,
        EBCS_T1    = 2'b01,
        EBCS_T2    = 2'b10,
        EBCS_GRANT = 2'b11
    } ebcs_state_t;
endpackage

// [ebcs_dec_if.sv]
// Carrier between the bus sequencer and the region decoder
`timescale 1ns/1ps
interface ebcs_dec_if;
    import ebcs_pkg::*;
    logic [ADDR_W-1:0] addr;     // Address to decode
    logic              active;   // An access is in progress
    logic              is_io;    // Access is in I/O space
    logic [NUM_CS-1:0] cs_n;     // Decoded selects, active low

    modport port (output addr, output active, output is_io, input cs_n);
    modport dec  (input addr, input active, input is_io, output cs_n);
endinterface

// [ebcs_region_decode.sv]
// Region decoder turning an address into at most one active-low select
`timescale 1ns/1ps
module ebcs_region_decode
    import ebcs_pkg::*;
(
    ebcs_dec_if.dec bus
);
    logic [NUM_CS-1:0] hit;      // Raw region matches
    logic [NUM_CS-1:0] win;      // Lowest-index match only

    // Per-region compare under mask, space must agree
    genvar g;
    generate
        for (g = 0; g < NUM_CS; g++)
        begin : g_region
            assign hit[g] = bus.active
                && (bus.is_io == REGION_IO[g])
                && ((bus.addr & REGION_MASK[g]) == (REGION_BASE[g] & REGION_MASK[g]));
        end
    endgenerate

    // Overlapping regions resolve to the lowest index, so two chips never fight
    always_comb
    begin
        win = hit & ~(hit - {{(NUM_CS-1){1'b0}}, 1'b1});
        bus.cs_n = ~win;
    end
endmodule // ebcs_region_decode

// [ebcs_port.sv]
// External bus port: bus cycle sequencer, pin drivers and bus takeover
`timescale 1ns/1ps
// Behaviour
// R1: Drive address pins in normal operation
// R2: Release address during takeover, external drives it
// R3: Address feeds the region select decoder
// R4: Four active-low selects, low inside region
// R5: Drive data only in own write cycles
// R6: Takeover request releases pins, grant goes low
// R7: Low wait input stretches the cycle
// R8: Memory or I/O strobe plus read/write
// R9: At most one select, none when idle
module ebcs_port
    import ebcs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              cpu_req,
    input  wire logic              cpu_write,
    input  wire logic              cpu_io,
    input  wire logic [ADDR_W-1:0] cpu_addr,
    input  wire logic [DATA_W-1:0] cpu_wdata,
    output logic                   cpu_ready,
    output logic                   cpu_done,
    output logic      [DATA_W-1:0] cpu_rdata,
    input  wire logic [ADDR_W-1:0] addr_in,
    output logic      [ADDR_W-1:0] addr_out,
    output logic                   addr_oe_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe_n,
    input  wire logic              memory_request_in_n,
    output logic                   memory_request_n,
    input  wire logic              io_request_in_n,
    output logic                   io_request_n,
    output logic                   read_n,
    output logic                   write_n,
    output logic                   ctrl_oe_n,
    input  wire logic              wait_n,
    input  wire logic              bus_takeover_request_n,
    output logic                   bus_takeover_grant_n,
    output logic                   region_select_0_n,
    output logic                   region_select_1_n,
    output logic                   region_select_2_n,
    output logic                   region_select_3_n
);
    import ebcs_pkg::*;

    ebcs_state_t       state_q, state_d;     // Sequencer state
    logic [ADDR_W-1:0] addr_q, addr_d;       // Address pin register
    logic [DATA_W-1:0] data_q, data_d;       // Write data pin register
    logic [DATA_W-1:0] rdata_q, rdata_d;     // Captured read data
    logic              write_q, write_d;     // Current access is a write
    logic              io_q, io_d;           // Current access is I/O
    logic              done_q, done_d;       // Access complete pulse
    logic [NUM_CS-1:0] cs_q, cs_d;           // Region selects, active low

    ebcs_dec_if dec_bus ();                  // Link to the region decoder

    ebcs_region_decode u_decode
    (
        .bus (dec_bus.dec)
    );

    // Requests are accepted only from idle with no takeover pending
    assign cpu_ready = (state_q == EBCS_IDLE) && bus_takeover_request_n;

    // Next-state and datapath for the bus cycle
    always_comb
    begin
        state_d = state_q;
        addr_d  = addr_q;
        data_d  = data_q;
        rdata_d = rdata_q;
        write_d = write_q;
        io_d    = io_q;
        done_d  = 1'b0;
        unique case (state_q)
            EBCS_IDLE:
            begin
                // R6: takeover wins over a new access
                if (!bus_takeover_request_n)
                begin
                    state_d = EBCS_GRANT;
                end
                else if (cpu_req)
                begin
                    state_d = EBCS_T1;
                    addr_d  = cpu_addr;
                    data_d  = cpu_wdata;
                    write_d = cpu_write;
                    io_d    = cpu_io;
                end
            end
            EBCS_T1:
            begin
                // First strobe cycle, always one clock
                state_d = EBCS_T2;
            end
            EBCS_T2:
            begin
                // R7: stretch while the slave holds wait low
                if (wait_n)
                begin
                    state_d = EBCS_IDLE;
                    done_d  = 1'b1;
                    if (!write_q)
                    begin
                        rdata_d = data_in;
                    end
                end
            end
            EBCS_GRANT:
            begin
                // Hold the bus off until the request is withdrawn
                if (bus_takeover_request_n)
                begin
                    state_d = EBCS_IDLE;
                end
            end
        endcase
    end

    // R3: the decoder sees our own address, or the foreign one during takeover
    always_comb
    begin
        if (state_d == EBCS_GRANT)
        begin
            dec_bus.addr   = addr_in;
            dec_bus.active = !memory_request_in_n || !io_request_in_n;
            dec_bus.is_io  = !io_request_in_n;
        end
        else
        begin
            dec_bus.addr   = addr_d;
            dec_bus.active = (state_d == EBCS_T1) || (state_d == EBCS_T2);
            dec_bus.is_io  = io_d;
        end
        cs_d = dec_bus.cs_n;
    end

    // Register stage; selects are registered so they line up with strobes
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_q <= EBCS_IDLE;
            addr_q  <= ADDR_RST;
            data_q  <= DATA_RST;
            rdata_q <= DATA_RST;
            write_q <= 1'b0;
            io_q    <= 1'b0;
            done_q  <= 1'b0;
            cs_q    <= CS_IDLE;
        end
        else
        begin
            state_q <= state_d;
            addr_q  <= addr_d;
            data_q  <= data_d;
            rdata_q <= rdata_d;
            write_q <= write_d;
            io_q    <= io_d;
            done_q  <= done_d;
            cs_q    <= cs_d;
        end
    end

    logic in_cycle;                          // T1 or T2
    assign in_cycle = (state_q == EBCS_T1) || (state_q == EBCS_T2);

    // R1: address driven from registers except while granted
    assign addr_out  = addr_q;
    // R2: address pins become inputs during takeover
    assign addr_oe_n = (state_q == EBCS_GRANT) ? OE_OFF : OE_ON;
    // R5: data pins driven only in our own write cycle
    assign data_out  = data_q;
    assign data_oe_n = (in_cycle && write_q) ? OE_ON : OE_OFF;
    // R8: space strobe and direction strobe during the cycle
    assign memory_request_n = (in_cycle && !io_q) ? STB_ON : STB_OFF;
    assign io_request_n     = (in_cycle && io_q) ? STB_ON : STB_OFF;
    assign read_n           = (in_cycle && !write_q) ? STB_ON : STB_OFF;
    assign write_n          = (in_cycle && write_q) ? STB_ON : STB_OFF;
    // R6: control released and grant asserted during takeover
    assign ctrl_oe_n            = (state_q == EBCS_GRANT) ? OE_OFF : OE_ON;
    assign bus_takeover_grant_n = (state_q == EBCS_GRANT) ? STB_ON : STB_OFF;
    // R4: region selects straight from their registers
    assign region_select_0_n = cs_q[0];
    assign region_select_1_n = cs_q[1];
    assign region_select_2_n = cs_q[2];
    assign region_select_3_n = cs_q[3];
    assign cpu_done  = done_q;
    assign cpu_rdata = rdata_q;

    // Accepted request runs T1 then T2
    sequence accept_s;
        cpu_req && cpu_ready;
    endsequence
    sequence cycle_s;
        (state_q == EBCS_T1) ##1 (state_q == EBCS_T2);
    endsequence

    // R8: request leads to a strobed cycle
    access_seq_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
        accept_s |=> cycle_s)
        else $error("Accepted request did not run T1 then T2");
    // R8: never both space strobes
    space_excl_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
        !(!memory_request_n && !io_request_n))
        else $error("Memory and I/O strobes both active");
    // R1: address held for whole cycle
    addr_drive_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
        (state_q == EBCS_T2) |-> (!addr_oe_n && addr_out == $past(addr_out)))
        else $error("Address not driven steady in cycle");
    // R2: address released during grant
    addr_release_a: assert property (@(posedge clk) disable iff (!reset_n) // R2
        !bus_takeover_grant_n |-> (addr_oe_n && ctrl_oe_n))
        else $error("Address or control driven while granted");
    // R6: idle takeover grants next cycle
    grant_resp_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
        ((state_q == EBCS_IDLE) && !bus_takeover_request_n)
        |=> (!bus_takeover_grant_n && data_oe_n))
        else $error("Takeover request not granted");
    // R5: data only in own writes
    data_drive_a: assert property (@(posedge clk) disable iff (!reset_n) // R5
        !data_oe_n |-> (!write_n && read_n && bus_takeover_grant_n))
        else $error("Data driven outside a write");
    // R7: low wait keeps the cycle open
    wait_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // R7
        ((state_q == EBCS_T2) && !wait_n) |=> ((state_q == EBCS_T2) && !cpu_done))
        else $error("Cycle ended while wait low");
    // R9: one select at most
    cs_onehot_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
        $onehot0(~cs_q))
        else $error("More than one region select active");
    // R9: no select when idle
    cs_idle_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
        (state_q == EBCS_IDLE) |-> (cs_q == CS_IDLE))
        else $error("Region select active while idle");
    // R4: own select only with a strobe
    cs_strobe_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
        ((cs_q != CS_IDLE) && bus_takeover_grant_n)
        |-> (!memory_request_n || !io_request_n))
        else $error("Region select without access strobe");
endmodule // ebcs_port

// [ebcs_far_mem.sv]
// Far-side memory model with programmable wait insertion
`timescale 1ns/1ps
module ebcs_far_mem
    import ebcs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              io_n,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [3:0]        waits,
    output logic      [DATA_W-1:0] rdata,
    output logic                   wait_n
);
    logic [DATA_W-1:0] mem [512];      // Store keyed by space and low address byte
    logic [3:0]        cnt_q = 4'h0;   // Cycles since a strobe fell
    logic [DATA_W-1:0] junk_q = 8'ha5; // Toggles so a released bus never looks stable
    logic [8:0]        key;            // Space bit and low address
    assign key = {~io_n, addr[7:0]};
    assign wait_n = !(cnt_q >= 4'h1 && cnt_q <= waits);
    // Data only while the read strobe is low, garbage otherwise
    assign rdata = !rd_n ? mem[key] : junk_q;
    // Unwritten cells hold a pattern derived from the address
    initial
        for (int i = 0; i < 512; i++)
            mem[i] = i[7:0] ^ 8'h5a;
    // Count strobe cycles; writes land only once no wait is held
    always @(posedge clk)
    begin
        cnt_q  <= (!rd_n || !wr_n) ? cnt_q + 4'h1 : 4'h0;
        junk_q <= ~junk_q;
        if (!wr_n && wait_n)
            mem[key] <= wdata;
    end
endmodule // ebcs_far_mem

// [external_bus_chip_select_port_test.sv]
// Self-checking bench for the external bus port
`timescale 1ns/1ps
module external_bus_chip_select_port_test;
    import ebcs_pkg::*;
    // Bench-driven inputs set at time zero; io, a and d are left unset until the main loop
    logic clk = 1'b0, reset_n = 1'b0, cpu_req = 1'b0, cpu_write = 1'b0, cpu_io = 1'b0;
    logic bus_takeover_request_n = 1'b1, m_memory_request_n_n = 1'b1, m_io_request_n_n = 1'b1, io;
    logic [ADDR_W-1:0] cpu_addr = '0, m_addr = '0, a;
    logic [DATA_W-1:0] cpu_wdata = '0, d;
    logic [3:0]        waits = '0;
    // Design outputs and resolved wires
    logic cpu_ready, cpu_done, addr_oe_n, data_oe_n, ctrl_oe_n, read_n, write_n, wait_n;
    logic memory_request_n, io_request_n, memory_request_in_n, io_request_in_n;
    logic bus_takeover_grant_n, region_select_0_n, region_select_1_n, region_select_2_n;
    logic region_select_3_n;
    logic [ADDR_W-1:0] addr_in, addr_out;
    logic [DATA_W-1:0] cpu_rdata, data_in, data_out, far_rdata;
    logic [3:0]        sel_n;
    logic [7:0]        model [int];    // Expected memory contents
    logic [23:0]       base [5] = '{24'h000000, 24'h040000, 24'h080000, 24'h000100, 24'hc00000};
    int                err_count = 0, checks_done = 0;
    // outside master owns the address while the port lets go
    assign addr_in = addr_oe_n ? m_addr : addr_out;
    assign data_in = data_oe_n ? far_rdata : data_out;
    assign memory_request_in_n = ctrl_oe_n ? m_memory_request_n_n : memory_request_n;
    assign io_request_in_n = ctrl_oe_n ? m_io_request_n_n : io_request_n;
    assign sel_n = {region_select_3_n, region_select_2_n, region_select_1_n, region_select_0_n};
    always #5 clk = ~clk;
    ebcs_port DUT (.clk, .reset_n, .cpu_req, .cpu_write, .cpu_io, .cpu_addr, .cpu_wdata,
        .cpu_ready, .cpu_done, .cpu_rdata, .addr_in, .addr_out, .addr_oe_n, .data_in,
        .data_out, .data_oe_n, .memory_request_in_n, .memory_request_n, .io_request_in_n,
        .io_request_n, .read_n, .write_n, .ctrl_oe_n, .wait_n, .bus_takeover_request_n,
        .bus_takeover_grant_n, .region_select_0_n, .region_select_1_n, .region_select_2_n,
        .region_select_3_n);
    // Released read and write strobes float high through the pull-ups
    ebcs_far_mem far (.clk(clk), .addr(addr_in), .wdata(data_in), .io_n(io_request_in_n),
        .rd_n(ctrl_oe_n | read_n), .wr_n(ctrl_oe_n | write_n), .waits(waits),
        .rdata(far_rdata), .wait_n(wait_n));
    // Expected select pattern; lowest index wins on overlap
    function automatic logic [3:0] exp_sel(logic [23:0] ad, logic sp);
        exp_sel = CS_IDLE;
        for (int i = NUM_CS - 1; i >= 0; i--)
            if (REGION_IO[i] == sp && (ad & REGION_MASK[i]) == REGION_BASE[i])
                exp_sel = ~(4'h1 << i);
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Read data against the bench copy of the far store; unwritten cells hold the fill pattern
    task automatic chk_rdata(logic sp, logic [23:0] ad);
        logic [7:0] e;
        e = model.exists({sp, ad[7:0]}) ? model[{sp, ad[7:0]}] : (ad[7:0] ^ 8'h5a);
        chk(cpu_rdata, e, "read data");
    endtask
    // One edge, then step clear of it before driving or sampling
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // Bounded wait for a flag to reach a level; counts edges taken
    task automatic wait_for(ref logic f, input logic lv, output int n);
        n = 0;
        while (f !== lv && n < 40)
        begin
            tick();
            n++;
        end
        if (n >= 40)
        begin
            err_count++;
            results();
        end
    endtask
    // One byte access; returns in the done cycle so calls run back to back
    task automatic access(logic wr, logic sp, logic [23:0] ad, logic [7:0] dv, int w);
        int n;
        cpu_req = 1'b1;
        cpu_write = wr;
        cpu_io = sp;
        cpu_addr = ad;
        cpu_wdata = dv;
        waits = w[3:0];
        wait_for(cpu_ready, 1'b1, n);
        tick();
        cpu_req = 1'b0;
        chk(addr_out, ad, "address");
        chk({memory_request_n, io_request_n, read_n, write_n}, {sp, !sp, wr, !wr}, "strobes");
        chk({data_oe_n, wr ? data_out : dv}, {!wr, dv}, "write data");
        chk(sel_n, exp_sel(ad, sp), "select");
        wait_for(cpu_done, 1'b1, n);
        chk(n, w + 2, "cycle length");
        chk({data_oe_n, sel_n}, {1'b1, CS_IDLE}, "idle pins");
        if (wr)
            model[{sp, ad[7:0]}] = dv;
        else
            chk_rdata(sp, ad);
    endtask
    // Main sequence
    initial
    begin
        int n;
        void'($urandom(32'h58ca));
        repeat (3) tick();
        chk({bus_takeover_grant_n, addr_oe_n, ctrl_oe_n, data_oe_n, sel_n, memory_request_n,
            io_request_n, read_n, write_n}, 12'h9ff, "reset pins");
        reset_n = 1'b1;
        access(1'b1, 1'b0, 24'h040010, 8'h3c, 0);
        access(1'b0, 1'b0, 24'h040010, 8'h00, 2);
        for (int i = 0; i < 24; i++)
        begin
            a = {base[$urandom_range(0, 4)][23:8], 8'($urandom)};
            io = 1'($urandom);
            d = 8'($urandom);
            access(1'b1, io, a, d, $urandom_range(0, 3));
            access(1'b0, io, a, 8'h00, $urandom_range(0, 3));
        end
        // Takeover with a refused request pending
        bus_takeover_request_n = 1'b0;
        m_addr = 24'h041234;
        m_memory_request_n_n = 1'b0;
        cpu_req = 1'b1;
        wait_for(bus_takeover_grant_n, 1'b0, n);
        chk(n, 1, "grant delay");
        chk({addr_oe_n, ctrl_oe_n, data_oe_n, cpu_ready}, 4'he, "released");
        tick();
        chk({sel_n, cpu_done}, {exp_sel(m_addr, 1'b0), 1'b0}, "foreign select");
        cpu_req = 1'b0;
        bus_takeover_request_n = 1'b1;
        m_memory_request_n_n = 1'b1;
        wait_for(bus_takeover_grant_n, 1'b1, n);
        chk({n[3:0], addr_oe_n, ctrl_oe_n}, 6'h04, "regained");
        access(1'b0, 1'b1, 24'h000155, 8'h00, 1);
        // Takeover raised inside an access waits for it, then foreign I/O is decoded
        cpu_req = 1'b1;
        cpu_write = 1'b0;
        cpu_io = 1'b0;
        cpu_addr = 24'h080020;
        waits = 4'h1;
        tick();
        cpu_req = 1'b0;
        bus_takeover_request_n = 1'b0;
        m_addr = 24'h000177;
        m_io_request_n_n = 1'b0;
        wait_for(cpu_done, 1'b1, n);
        chk({n[3:0], bus_takeover_grant_n, cpu_ready}, 6'h0e, "late takeover");
        chk(sel_n, CS_IDLE, "select after access");
        chk_rdata(1'b0, 24'h080020);
        wait_for(bus_takeover_grant_n, 1'b0, n);
        chk({n[3:0], addr_oe_n, ctrl_oe_n}, 6'h07, "late grant");
        tick();
        chk(sel_n, exp_sel(m_addr, 1'b1), "foreign io select");
        bus_takeover_request_n = 1'b1;
        m_io_request_n_n = 1'b1;
        wait_for(bus_takeover_grant_n, 1'b1, n);
        chk({n[3:0], addr_oe_n, ctrl_oe_n}, 6'h04, "io regained");
        results();
    end
endmodule // external_bus_chip_select_port_test
